// ==== include/flash_timing_pkg.sv ====
// Purpose: Shared constants, types and the divider table for flash timing control.
// Assumes: One system clock at 50 MHz; all requests arrive on that clock.
// Notes:   The configuration struct is the exact bit layout of the config register.
package flash_timing_pkg;

  // System clock rate
  localparam int CLK_MHZ = 50;

  // Widths
  localparam int CFG_W   = 8;
  localparam int SPEED_W = 8;
  localparam int ADDR_W  = 16;
  localparam int DATA_W  = 16;
  localparam int DIV_W   = 9;

  // Field positions inside the config register
  localparam int EXEC_WAIT_LSB = 6;
  localparam int READ_ACC_LSB  = 4;
  localparam int PROG_DIV_LSB  = 0;

  // Reset value: slowest flash execution and read timing, smallest divider
  localparam logic [CFG_W-1:0] CFG_RESET = 8'hF0;

  // An erase clears 512 bytes, which is 256 words: the low address bits are dropped
  localparam int                BLOCK_WORD_BITS = 8;
  localparam logic [ADDR_W-1:0] BLOCK_MASK      = 16'hFF00;

  // Config register layout
  typedef struct packed {
    logic [1:0] exec_wait_select;
    logic [1:0] read_access_cycles;
    logic [3:0] program_clock_divider_select;
  } cfg_s;

  // Request towards the flash array
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic              erase;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } flash_req_s;

  // Operation sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_PROG
  } op_state_e;

  // Core clocks per program time base tick for each divider code
  function automatic logic [DIV_W-1:0] prog_divisor(input logic [3:0] code);
    logic [DIV_W-1:0] d;
    d = 9'h002;
    case (code)
      4'h0:    d = 9'h002;
      4'h1:    d = 9'h003;
      4'h2:    d = 9'h004;
      4'h3:    d = 9'h006;
      4'h4:    d = 9'h008;
      4'h5:    d = 9'h00C;
      4'h6:    d = 9'h010;
      4'h7:    d = 9'h018;
      4'h8:    d = 9'h020;
      4'h9:    d = 9'h030;
      4'hA:    d = 9'h040;
      4'hB:    d = 9'h060;
      4'hC:    d = 9'h080;
      4'hD:    d = 9'h0C0;
      4'hE:    d = 9'h100;
      default: d = 9'h180;
    endcase
    return d;
  endfunction : prog_divisor

endpackage : flash_timing_pkg

// ==== rtl/flash_time_base.sv ====
// Purpose: Divides core clock ticks into the erase and write time base.
// Assumes: core_tick is a one-cycle pulse per core clock on clk.
// Notes:   Counter restarts whenever run is low so each operation starts clean.
`timescale 1ns/100ps
module flash_time_base
  import flash_timing_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  // Control
  input  wire logic       run,
  input  wire logic       core_tick,
  input  wire logic [3:0] div_code,
  // Time base pulse
  output logic            tick
);
  import flash_timing_pkg::*;

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic             next_tick;
  logic [DIV_W-1:0] divisor;

  // Count core ticks and pulse on the last one of each period
  always_comb begin
    divisor   = prog_divisor(div_code);
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = '0;
    end else if (core_tick) begin
      if (cnt + 9'h001 >= divisor) begin
        next_cnt  = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 9'h001;
      end
    end
  end

  // Register state
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !ce);

  property p_div_period;
    run && core_tick && (cnt + 9'h001 == prog_divisor(div_code)) |=> tick;
  endproperty
  a_div_period: assert property (p_div_period) else $error("time base tick missing");

  property p_tick_needs_run;
    tick && $past(ce) |-> $past(run) && $past(core_tick);
  endproperty
  a_tick_needs_run: assert property (p_tick_needs_run) else $error("tick without run");

endmodule : flash_time_base

// ==== rtl/flash_timing_control.sv ====
// Purpose: Flash timing control: core clock stretching, read timing, program time base.
// Assumes: Commands, config writes and the flash array all run on clk.
// Notes:   Commands arriving while an operation is pending are ignored.
`timescale 1ns/100ps
// Notes on behaviour
// - From flash, each core cycle lasts at least exec_wait_select plus one system clocks.
// - The core tick period is the slower of core_speed_setting and the flash wait.
// - A read takes read_access_cycles plus one core clock cycles.
// - The erase and write time base is the core clock through a programmable divider.
// - Divider codes 0 to 15 map to 2,3,4,6,8,12,16,24,32,48,64,96,128,192,256,384.
// - With a read timing of one cycle, interrupts cannot make a read fail.
// - Commands start in one cycle and a pending flag holds until completion.
// - Erase clears a whole 512-byte block, addressed by its aligned block base.
module flash_timing_control
  import flash_timing_pkg::*;
(
  // Clock, reset and enable
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        ce,
  // Config register access
  input  wire logic                        cfg_wr,
  input  wire logic [CFG_W-1:0]            cfg_wdata,
  output flash_timing_pkg::cfg_s           cfg_rdata,
  // Core speed
  input  wire logic [SPEED_W-1:0]          core_speed_setting,
  input  wire logic                        exec_from_flash,
  output logic                             core_tick,
  // Commands
  input  wire logic                        cmd_read,
  input  wire logic                        cmd_write,
  input  wire logic                        cmd_erase,
  input  wire logic [ADDR_W-1:0]           cmd_addr,
  input  wire logic [DATA_W-1:0]           cmd_wdata,
  output logic                             flash_op_pending,
  output logic [DATA_W-1:0]                read_data,
  output logic                             read_done,
  // Flash array
  output flash_timing_pkg::flash_req_s     flash_req,
  output logic                             flash_time_base,
  input  wire logic [DATA_W-1:0]           flash_rdata,
  input  wire logic                        flash_prog_done
);
  import flash_timing_pkg::*;

  cfg_s             cfg;
  cfg_s             next_cfg;
  logic [SPEED_W-1:0] core_cnt;
  logic [SPEED_W-1:0] next_core_cnt;
  logic             next_core_tick;
  logic [SPEED_W-1:0] spd_div;
  logic [SPEED_W-1:0] wait_div;
  logic [SPEED_W-1:0] eff_div;
  op_state_e        state;
  op_state_e        next_state;
  logic [1:0]       acc_cnt;
  logic [1:0]       next_acc_cnt;
  flash_req_s       next_req;
  logic             next_pending;
  logic [DATA_W-1:0] next_read_data;
  logic             next_read_done;
  logic             start;

  assign cfg_rdata = cfg;

  // Config register: written whole, otherwise held
  always_comb begin
    next_cfg = cfg;
    if (cfg_wr) begin
      next_cfg = cfg_s'(cfg_wdata);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg <= cfg_s'(CFG_RESET);
    end else if (ce) begin
      cfg <= next_cfg;
    end
  end

  // Core clock period: slower of speed setting and flash execution wait
  always_comb begin
    spd_div  = (core_speed_setting == 8'h00) ? 8'h01 : core_speed_setting;
    wait_div = exec_from_flash ? ({6'h00, cfg.exec_wait_select} + 8'h01) : 8'h01;
    eff_div  = (wait_div > spd_div) ? wait_div : spd_div;
    next_core_tick = (core_cnt + 8'h01 >= eff_div);
    next_core_cnt  = next_core_tick ? 8'h00 : core_cnt + 8'h01;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      core_cnt  <= '0;
      core_tick <= 1'b0;
    end else if (ce) begin
      core_cnt  <= next_core_cnt;
      core_tick <= next_core_tick;
    end
  end

  // Operation sequencer: one-cycle start, pending until the array finishes
  assign start = (state == ST_IDLE) && (cmd_read || cmd_write || cmd_erase);

  always_comb begin
    next_state     = state;
    next_acc_cnt   = acc_cnt;
    next_req       = flash_req;
    next_pending   = flash_op_pending;
    next_read_data = read_data;
    next_read_done = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_pending   = 1'b1;
          next_acc_cnt   = 2'b00;
          next_req.addr  = cmd_addr;
          next_req.wdata = cmd_wdata;
          if (cmd_erase) begin
            next_req.erase = 1'b1;
            next_req.addr  = cmd_addr & BLOCK_MASK;
            next_state     = ST_PROG;
          end else if (cmd_write) begin
            next_req.wr = 1'b1;
            next_state  = ST_PROG;
          end else begin
            next_req.rd = 1'b1;
            next_state  = ST_READ;
          end
        end
      end
      ST_READ: begin
        // Only core ticks count, so a single-cycle read ends on the first tick
        if (core_tick) begin
          if (acc_cnt == cfg.read_access_cycles) begin
            next_read_data = flash_rdata;
            next_read_done = 1'b1;
            next_req.rd    = 1'b0;
            next_pending   = 1'b0;
            next_state     = ST_IDLE;
          end else begin
            next_acc_cnt = acc_cnt + 2'b01;
          end
        end
      end
      ST_PROG: begin
        if (flash_prog_done) begin
          next_req.wr    = 1'b0;
          next_req.erase = 1'b0;
          next_pending   = 1'b0;
          next_state     = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state            <= ST_IDLE;
      acc_cnt          <= '0;
      flash_req        <= '0;
      flash_op_pending <= 1'b0;
      read_data        <= '0;
      read_done        <= 1'b0;
    end else if (ce) begin
      state            <= next_state;
      acc_cnt          <= next_acc_cnt;
      flash_req        <= next_req;
      flash_op_pending <= next_pending;
      read_data        <= next_read_data;
      read_done        <= next_read_done;
    end
  end

  // Erase and write time base, running only during a program operation
  flash_time_base u_time_base (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .run       (state == ST_PROG),
    .core_tick (core_tick),
    .div_code  (cfg.program_clock_divider_select),
    .tick      (flash_time_base)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !ce);

  sequence s_slow_wait;
    core_tick && exec_from_flash && cfg.exec_wait_select == 2'b11 && core_speed_setting <= 8'h01
      && !cfg_wr;
  endsequence

  // Settings that keep the four-cycle flash wait in force for a whole period
  sequence s_wait_held;
    exec_from_flash && cfg.exec_wait_select == 2'b11 && core_speed_setting <= 8'h01 && !cfg_wr;
  endsequence

  property p_exec_wait;
    s_slow_wait ##1 s_wait_held [*3] |->
      (!core_tick && !$past(core_tick) && !$past(core_tick, 2)) ##1 core_tick;
  endproperty
  a_exec_wait: assert property (p_exec_wait) else $error("flash wait period wrong");

  property p_slower_wins;
    core_tick && $past(ce) |-> ($past(core_cnt) + 8'h01 >= $past(spd_div))
      && ($past(core_cnt) + 8'h01 >= $past(wait_div));
  endproperty
  a_slower_wins: assert property (p_slower_wins) else $error("core tick too early");

  sequence s_read_last;
    state == ST_READ && core_tick && acc_cnt == cfg.read_access_cycles;
  endsequence

  property p_read_len;
    s_read_last |=> read_done && !flash_op_pending && state == ST_IDLE;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read did not end");

  property p_read_one;
    state == ST_READ && cfg.read_access_cycles == 2'b00 && core_tick |=> read_done;
  endproperty
  a_read_one: assert property (p_read_one) else $error("single cycle read failed");

  property p_no_early_read;
    state == ST_READ && acc_cnt != cfg.read_access_cycles |=> !read_done;
  endproperty
  a_no_early_read: assert property (p_no_early_read) else $error("read ended early");

  property p_pending_set;
    start |=> flash_op_pending;
  endproperty
  a_pending_set: assert property (p_pending_set) else $error("pending not set");

  property p_prog_end;
    state == ST_PROG && flash_prog_done |=> !flash_op_pending && !flash_req.wr && !flash_req.erase;
  endproperty
  a_prog_end: assert property (p_prog_end) else $error("pending not cleared");

  property p_erase_block;
    start && cmd_erase |=> flash_req.erase && flash_req.addr[BLOCK_WORD_BITS-1:0] == 8'h00;
  endproperty
  a_erase_block: assert property (p_erase_block) else $error("erase not block aligned");

  property p_cfg_hold;
    !cfg_wr |=> $stable(cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed unwritten");

  property p_cfg_write;
    cfg_wr |=> cfg == $past(cfg_wdata);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

endmodule : flash_timing_control

// ==== testbench/flash_array_model.sv ====
// Purpose: Behavioural flash array that answers reads and program operations.
// Assumes: The request is held for the whole operation.
// Notes:   Outside a read the data bus carries junk that inverts every cycle.
`timescale 1ns/100ps
module flash_array_model
  import flash_timing_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // Pace: high needs one more time base pulse
  input  wire logic                        slow,
  // Request side
  input  wire flash_timing_pkg::flash_req_s req,
  input  wire logic                        time_base,
  output logic [DATA_W-1:0]                rdata,
  output logic                             prog_done
);
  import flash_timing_pkg::*;
  logic [3:0]        n_base;
  logic [DATA_W-1:0] junk;
  // Read word follows the address
  always_comb rdata = req.rd ? (req.addr ^ 16'h5A3C) : junk;
  // Count time base pulses of a program operation
  always_ff @(posedge clk) begin
    junk <= srst ? 16'hA5A5 : ~junk;
    if (srst || !(req.wr || req.erase)) begin
      n_base    <= 4'h0;
      prog_done <= 1'b0;
    end else begin
      n_base    <= n_base + {3'b000, time_base};
      prog_done <= (n_base + {3'b000, time_base}) >= (4'h3 + {3'b000, slow});
    end
  end
endmodule : flash_array_model

// ==== testbench/flash_timing_control_tb.sv ====
// Purpose: Self-checking bench for the flash timing control block.
// Assumes: Software side is played by the bench, the array by a model.
// Notes:   Random fields come from a fixed seed.
`timescale 1ns/100ps
module flash_timing_control_tb;
  import flash_timing_pkg::*;
  logic              clk = 0, srst = 1, ce = 1, cfg_wr = 0, exec_from_flash = 0, slow = 0;
  logic [7:0]        cfg_wdata = 0, core_speed_setting = 1;
  logic              cmd_read = 0, cmd_write = 0, cmd_erase = 0;
  logic [15:0]       cmd_addr = 0, cmd_wdata = 0, read_data, flash_rdata;
  cfg_s              cfg_rdata;
  flash_req_s        flash_req;
  logic              core_tick, flash_op_pending, read_done, flash_time_base, flash_prog_done;
  int                n_mismatch = 0, tests_run = 0;
  int                divs [16] = '{2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192, 256, 384};

  flash_timing_control u_flash_timing_control (.clk(clk), .srst(srst), .ce(ce),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .core_speed_setting(core_speed_setting), .exec_from_flash(exec_from_flash),
    .core_tick(core_tick), .cmd_read(cmd_read), .cmd_write(cmd_write),
    .cmd_erase(cmd_erase), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .flash_op_pending(flash_op_pending), .read_data(read_data), .read_done(read_done),
    .flash_req(flash_req), .flash_time_base(flash_time_base),
    .flash_rdata(flash_rdata), .flash_prog_done(flash_prog_done));
  flash_array_model u_flash_array_model (.clk(clk), .srst(srst), .slow(slow),
    .req(flash_req), .time_base(flash_time_base), .rdata(flash_rdata),
    .prog_done(flash_prog_done));

  // Clock
  always #10 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Expected core tick period
  function automatic int exp_period(input int s, input int w, input int f);
    int p;
    int q;
    p = (s == 0) ? 1 : s;
    q = f ? w + 1 : 1;
    return (p > q) ? p : q;
  endfunction : exp_period

  task automatic wr_cfg(input logic [7:0] v);
    @(posedge clk);
    cfg_wr    <= 1'b1;
    cfg_wdata <= v;
    @(posedge clk);
    cfg_wr <= 1'b0;
    @(negedge clk);
    check("cfg_rdata", cfg_rdata, v);
  endtask : wr_cfg

  task automatic issue(input int k, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    cmd_read  <= (k == 0);
    cmd_write <= (k == 1);
    cmd_erase <= (k == 2);
    cmd_addr  <= a;
    cmd_wdata <= d;
    @(posedge clk);
    {cmd_read, cmd_write, cmd_erase} <= 3'b000;
    @(negedge clk);
  endtask : issue

  // Cycles from one pulse to the next (core tick or time base)
  task automatic gap(input logic tb_sel, output int g);
    int i;
    for (i = 0; i < 2000 && (tb_sel ? flash_time_base : core_tick) !== 1'b1; i++)
      @(negedge clk);
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while ((tb_sel ? flash_time_base : core_tick) !== 1'b1 && g < 2000);
  endtask : gap

  // Main sequence
  initial begin
    int          s, g, k, cnt, op;
    logic        last;
    logic [15:0] a, d;
    void'($urandom(54));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check("cfg_reset", cfg_rdata, CFG_RESET);
    check("pending_reset", flash_op_pending, 1'b0);
    // Clock enable low: a write is not taken and the core clock stands still
    @(posedge clk);
    ce                 <= 1'b0;
    cfg_wr             <= 1'b1;
    cfg_wdata          <= 8'h3C;
    core_speed_setting <= 8'h02;
    repeat (3) @(posedge clk);
    cfg_wr <= 1'b0;
    @(negedge clk);
    check("ce_hold_tick", core_tick, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    @(negedge clk);
    check("ce_hold_cfg", cfg_rdata, CFG_RESET);
    // Core tick period for every wait code, from flash and from RAM
    for (k = 0; k < 8; k++) begin
      s = (k == 7) ? 1 : (k == 1) ? $urandom_range(5, 2) : $urandom_range(5, 0);
      wr_cfg({k[2:1], 2'($urandom), 4'($urandom)});
      @(posedge clk);
      core_speed_setting <= 8'(s);
      exec_from_flash    <= k[0];
      @(negedge clk);
      gap(1'b0, g);
      gap(1'b0, g);
      check("core_tick_gap", g, exp_period(s, k / 2, k % 2));
    end
    // Read access length for every read timing code
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      core_speed_setting <= 8'((k == 0) ? $urandom_range(3, 2) : $urandom_range(3, 1));
      exec_from_flash    <= 1'b0;
      wr_cfg({2'($urandom), k[1:0], 4'($urandom)});
      a = 16'($urandom);
      issue(0, a, 16'h0000);
      check("read_pending", flash_op_pending, 1'b1);
      cnt  = 0;
      last = 1'b0;
      for (g = 0; g < 2000 && read_done !== 1'b1; g++) begin
        cnt += core_tick;
        last = core_tick;
        @(negedge clk);
      end
      check("read_ticks", cnt, k + 1);
      check("read_last_tick", last, 1'b1);
      check("read_data", read_data, a ^ 16'h5A3C);
      check("read_end", flash_op_pending, 1'b0);
    end
    // Time base for every divider code, writes and erases
    for (k = 0; k < 16; k++) begin
      // Time base near two microseconds; the largest divisors overshoot at this clock
      s = (divs[k] > 100) ? 1 : 100 / divs[k];
      @(posedge clk);
      core_speed_setting <= 8'(s);
      slow               <= 1'($urandom);
      wr_cfg({2'($urandom), 1'b1, 1'($urandom), k[3:0]});
      a  = 16'($urandom);
      d  = 16'($urandom);
      op = $urandom_range(2, 1);
      issue(op, a, d);
      check("prog_kind", {flash_req.wr, flash_req.erase}, (op == 1) ? 2'b10 : 2'b01);
      check("prog_addr", flash_req.addr, (op == 2) ? (a & BLOCK_MASK) : a);
      check("prog_wdata", flash_req.wdata, d);
      gap(1'b1, g);
      gap(1'b1, g);
      check("base_gap", g, divs[k] * s);
      issue(0, ~a, d);
      check("refused_read", flash_req.rd, 1'b0);
      for (g = 0; g < 5000 && flash_op_pending !== 1'b0; g++)
        @(negedge clk);
      check("prog_end", flash_op_pending, 1'b0);
    end
    tally_and_finish();
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : flash_timing_control_tb
